// File: rtl/dsak_device.sv
// Data slot store: address decode, access policy, key nibble, hash feed
module dsak_device (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Command link
  dsak_link_if.dev link,
  // Slot configuration
  input wire logic [15:0] validation_slots_i,
  // Byte feed toward the hash engine
  output logic sha_valid_o,
  output logic [7:0] sha_byte_o,
  output logic sha_last_o
);

  //------------------------------------------------------------------
  // State
  //------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b001, // Waiting for a command
    S_STREAM = 3'b010, // Feeding key bytes out
    S_RESP = 3'b100 // Answer cycle
  } dsak_dst_t;

  typedef struct packed {
    dsak_dst_t st; // Control state
    logic req_ready; // Link ready
    logic rsp_valid; // Answer strobe
    logic [7:0] rsp_status; // Answer status
    logic [31:0] rsp_data; // Answer word
    logic [7:0][3:0] vnib; // Validation nibbles, slots 8-15
    logic genkey; // Stream drops pad bytes
    logic [3:0] slot; // Streamed slot
    logic [7:0] base; // First word of streamed slot
    logic [6:0] bcnt; // Byte within stored layout
    logic [4:0] pcnt; // Leading pad bytes still due
    logic sha_valid; // Byte strobe
    logic [7:0] sha_byte; // Byte value
    logic sha_last; // Final byte marker
  } dsak_dstate_t;

  dsak_dstate_t s; // Registered state
  dsak_dstate_t n; // Next state
  dsak_pkg::dsak_loc_t loc; // Decode of request address
  dsak_pkg::dsak_loc_t loc0; // Decode of slot's first word
  logic [3:0] slot; // Requested slot
  logic [31:0] mem [dsak_pkg::MEM_WORDS]; // Slot words 8-15
  logic mem_we; // Storage write strobe
  logic [31:0] rd; // Word at the request address
  logic [31:0] sw; // Word under the stream pointer
  logic [7:0] sbyte; // Byte under the stream pointer
  logic [7:0] sidx; // Stream word index

  //------------------------------------------------------------------
  // Storage
  //------------------------------------------------------------------
  // No reset on the array: contents are nonvolatile, not control state
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[loc.idx] <= link.req_data;
    end
  end

  // Read ports for the answer and the stream
  always_comb begin
    sidx = 8'(s.base + {3'b000, s.bcnt[6:2]});
    rd = mem[loc.idx];
    sw = mem[sidx];
    sbyte = sw[8*(3-int'(s.bcnt[1:0]))+:8];
    // Stored digest sees the nibble as it is held
    if (s.bcnt == 7'h00 && validation_slots_i[s.slot]) begin
      sbyte[7:4] = s.vnib[s.slot[2:0]];
    end
  end

  //------------------------------------------------------------------
  // Next state
  //------------------------------------------------------------------
  always_comb begin
    n = s;
    slot = link.req_addr[dsak_pkg::SLOT_LSB+:4];
    loc = dsak_pkg::dsak_decode(link.req_addr);
    loc0 = dsak_pkg::dsak_decode(dsak_pkg::dsak_key_addr(slot, 5'h00));
    mem_we = 1'b0;
    n.rsp_valid = 1'b0;
    n.sha_valid = 1'b0;
    n.sha_last = 1'b0;
    unique case (s.st)
      S_IDLE: begin
        if (link.req_valid && s.req_ready) begin
          n.req_ready = 1'b0;
          n.st = S_RESP;
          n.rsp_valid = 1'b1;
          // Refusal unless a branch below accepts
          n.rsp_status = dsak_pkg::STATUS_EXEC_ERR;
          n.rsp_data = 32'h00000000;
          case (link.req_cmd)
            dsak_pkg::CMD_READ: begin
              if (loc.ok && dsak_pkg::READ_MASK[slot]) begin
                n.rsp_status = dsak_pkg::STATUS_OK;
                n.rsp_data = rd;
                // Nibble lives in its own flops, overrides stored bits
                if (loc.first && validation_slots_i[slot]) begin
                  n.rsp_data[31:28] = s.vnib[slot[2:0]];
                end
              end
            end
            dsak_pkg::CMD_WRITE: begin
              // Bad offsets never reach the array
              if (loc.ok && dsak_pkg::WRITE_MASK[slot]) begin
                mem_we = 1'b1;
                n.rsp_status = dsak_pkg::STATUS_OK;
                if (loc.key && validation_slots_i[slot]) begin
                  n.vnib[slot[2:0]] = dsak_pkg::NIB_INVALID;
                end
              end
            end
            dsak_pkg::CMD_WRITE_ENC: begin
              // Low slots are held elsewhere; only the policy is here
              if (dsak_pkg::ENC_MASK[slot]) begin
                n.rsp_status = dsak_pkg::STATUS_OK;
              end
            end
            dsak_pkg::CMD_VALIDATE: begin
              if (slot[3] && validation_slots_i[slot]) begin
                n.vnib[slot[2:0]] = dsak_pkg::NIB_VALID;
                n.rsp_status = dsak_pkg::STATUS_OK;
              end
            end
            dsak_pkg::CMD_INVALIDATE: begin
              if (slot[3] && validation_slots_i[slot]) begin
                n.vnib[slot[2:0]] = dsak_pkg::NIB_INVALID;
                n.rsp_status = dsak_pkg::STATUS_OK;
              end
            end
            dsak_pkg::CMD_HASH_GENKEY, dsak_pkg::CMD_HASH_STORED: begin
              // Only slots 8-15 can hold a public key
              if (slot[3]) begin
                n.st = S_STREAM;
                n.rsp_valid = 1'b0;
                n.slot = slot;
                n.base = loc0.idx;
                n.genkey = (link.req_cmd == dsak_pkg::CMD_HASH_GENKEY);
                if (n.genkey) begin
                  n.bcnt = dsak_pkg::GK_FIRST_BYTE;
                  n.pcnt = dsak_pkg::GENKEY_PAD;
                end else begin
                  n.bcnt = 7'h00;
                  n.pcnt = 5'h00;
                end
              end
            end
            default: begin
              // Unknown command keeps the refusal
            end
          endcase
        end
      end
      S_STREAM: begin
        n.sha_valid = 1'b1;
        if (s.pcnt != 5'h00) begin
          // Zero padding ahead of the coordinates
          n.sha_byte = 8'h00;
          n.pcnt = 5'(s.pcnt - 5'h01);
        end else begin
          n.sha_byte = sbyte;
          if (s.genkey && s.bcnt == dsak_pkg::GK_SKIP_FROM) begin
            n.bcnt = dsak_pkg::GK_SKIP_TO;
          end else begin
            n.bcnt = 7'(s.bcnt + 7'h01);
          end
          if (s.bcnt == dsak_pkg::KEY_LAST_BYTE) begin
            n.sha_last = 1'b1;
            n.st = S_RESP;
            n.rsp_valid = 1'b1;
            n.rsp_status = dsak_pkg::STATUS_OK;
            n.rsp_data = 32'h00000000;
          end
        end
      end
      S_RESP: begin
        n.req_ready = 1'b1;
        n.st = S_IDLE;
      end
      default: begin
        // Illegal one-hot code recovers to idle
        n.st = S_IDLE;
        n.req_ready = 1'b1;
      end
    endcase
  end

  //------------------------------------------------------------------
  // State register
  //------------------------------------------------------------------
  // Keys come up invalid until a validate command says otherwise
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '0;
      s.st <= S_IDLE;
      s.req_ready <= 1'b1;
      s.vnib <= {8{dsak_pkg::NIB_INVALID}};
    end else begin
      s <= n;
    end
  end

  //------------------------------------------------------------------
  // Outputs
  //------------------------------------------------------------------
  assign link.req_ready = s.req_ready;
  assign link.rsp_valid = s.rsp_valid;
  assign link.rsp_status = s.rsp_status;
  assign link.rsp_data = s.rsp_data;
  assign sha_valid_o = s.sha_valid;
  assign sha_byte_o = s.sha_byte;
  assign sha_last_o = s.sha_last;

endmodule

// File: rtl/dsak_pkg.sv
// Shared constants, types and helper functions of the data slot link
//------------------------------------------------------------------
//------------------------------------------------------------------
package dsak_pkg;

  //------------------------------------------------------------------
  // Commands and answers
  //------------------------------------------------------------------
  localparam logic [2:0] CMD_READ = 3'h0; // One word read
  localparam logic [2:0] CMD_WRITE = 3'h1; // One word clear write
  localparam logic [2:0] CMD_WRITE_ENC = 3'h2; // Encrypted write
  localparam logic [2:0] CMD_VALIDATE = 3'h3; // Mark key valid
  localparam logic [2:0] CMD_INVALIDATE = 3'h4; // Mark key invalid
  localparam logic [2:0] CMD_HASH_GENKEY = 3'h5; // Key hash message
  localparam logic [2:0] CMD_HASH_STORED = 3'h6; // Stored layout stream
  localparam logic [7:0] STATUS_OK = 8'h00; // Success
  localparam logic [7:0] STATUS_EXEC_ERR = 8'h0f; // Execution error

  //------------------------------------------------------------------
  // Address fields and slot geometry
  //------------------------------------------------------------------
  localparam int SLOT_LSB = 3; // Slot number at bits 6:3
  localparam int BLK_LSB = 8; // Block number starts at bit 8
  localparam logic [3:0] SLOT8 = 4'h8; // The big slot
  localparam logic [3:0] SLOT9 = 4'h9; // First of the 72-byte slots
  localparam logic [3:0] SLOT8_LAST_BLK = 4'hc; // Last block of slot 8
  localparam logic [1:0] LARGE_LAST_BLK = 2'h2; // Short block of 9-15
  localparam logic [2:0] LARGE_LAST_OFF = 3'h1; // Last word in block 2
  localparam logic [7:0] LARGE_BASE = 8'h68; // 104 words of slot 8
  localparam logic [7:0] LARGE_WORDS = 8'h12; // 18 words per slot
  localparam logic [7:0] KEY_WORDS = 8'h12; // Stored key is 18 words
  localparam logic [4:0] KEY_LAST_WORD = 5'h11; // Word 17
  localparam int MEM_WORDS = 230; // 104 + 7 * 18
  localparam logic [15:0] READ_MASK = 16'hfd00; // Slots 8, 10-15
  localparam logic [15:0] WRITE_MASK = 16'ha300; // Slots 8, 9, 13, 15
  localparam logic [15:0] ENC_MASK = 16'h0060; // Slots 5, 6

  //------------------------------------------------------------------
  // Key layout and validation nibble
  //------------------------------------------------------------------
  localparam logic [3:0] NIB_INVALID = 4'ha; // Key not validated
  localparam logic [3:0] NIB_VALID = 4'h5; // Key validated
  localparam logic [6:0] KEY_LAST_BYTE = 7'h47; // Byte 71
  localparam logic [6:0] GK_FIRST_BYTE = 7'h04; // First X byte
  localparam logic [6:0] GK_SKIP_FROM = 7'h23; // Last X byte, 35
  localparam logic [6:0] GK_SKIP_TO = 7'h28; // First Y byte, 40
  localparam logic [4:0] GENKEY_PAD = 5'h19; // 25 pad bytes

  // Decoded location of one word
  typedef struct packed {
    logic ok; // Address inside the slot
    logic key; // Word lies in the 72-byte key area
    logic first; // First word of the slot
    logic [7:0] idx; // Word index in storage
  } dsak_loc_t;

  // Word address decode for slots 8 to 15
  function automatic dsak_loc_t dsak_decode(input logic [15:0] addr);
    dsak_loc_t l;
    logic [3:0] slot;
    logic [2:0] off;
    logic [7:0] rel;
    l = '0;
    slot = addr[SLOT_LSB+:4];
    off = addr[2:0];
    rel = 8'h00;
    if (slot == SLOT8) begin
      // Bits 15:12 and 7 are ignored
      rel = {1'b0, addr[BLK_LSB+:4], off};
      l.ok = addr[BLK_LSB+:4] <= SLOT8_LAST_BLK;
      l.idx = rel;
    end else if (slot > SLOT8) begin
      // Bits 15:10 and 7 are ignored
      rel = {3'b000, addr[BLK_LSB+:2], off};
      l.ok = (addr[BLK_LSB+:2] < LARGE_LAST_BLK) ||
             (addr[BLK_LSB+:2] == LARGE_LAST_BLK &&
              off <= LARGE_LAST_OFF);
      l.idx = 8'(LARGE_BASE + 8'(slot - SLOT9) * LARGE_WORDS + rel);
    end
    l.key = l.ok && (rel < KEY_WORDS);
    l.first = l.ok && (rel == 8'h00);
    return l;
  endfunction

  // Address of word k of a slot's key area
  function automatic logic [15:0] dsak_key_addr(input logic [3:0] slot,
                                                input logic [4:0] k);
    return {6'h00, k[4:3], 1'b0, slot, k[2:0]};
  endfunction

  // Word k of the 72-byte stored key, MSB first
  function automatic logic [31:0] dsak_stored_word(input logic [255:0] x,
                                                   input logic [255:0] y,
                                                   input logic [4:0] k);
    logic [31:0] w;
    w = 32'h00000000;
    if (k >= 5'h01 && k <= 5'h08) begin
      w = x[32*(8-int'(k))+:32];
    end else if (k >= 5'h0a && k <= KEY_LAST_WORD) begin
      w = y[32*(17-int'(k))+:32];
    end
    return w;
  endfunction

endpackage

// File: rtl/dsak_link_if.sv
// Word link between the command host and the data slot device
interface dsak_link_if;
  logic req_valid; // Host offers a command
  logic req_ready; // Device can take a command
  logic [2:0] req_cmd; // Command code
  logic [15:0] req_addr; // Word address
  logic [31:0] req_data; // Write word, MSB is lowest byte
  logic rsp_valid; // One-cycle answer strobe
  logic [7:0] rsp_status; // Answer status
  logic [31:0] rsp_data; // Read word

  modport dev (
    input req_valid, req_cmd, req_addr, req_data,
    output req_ready, rsp_valid, rsp_status, rsp_data
  );
  modport host (
    output req_valid, req_cmd, req_addr, req_data,
    input req_ready, rsp_valid, rsp_status, rsp_data
  );
endinterface

// File: rtl/dsak_host.sv
// Command host end: word commands, key store sequence, parameter layout
module dsak_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Command link
  dsak_link_if.host link,
  // Single word operation
  input wire logic op_valid_i,
  input wire logic [2:0] op_cmd_i,
  input wire logic [15:0] op_addr_i,
  input wire logic [31:0] op_data_i,
  output logic op_ready_o,
  output logic done_o,
  output logic [7:0] status_o,
  output logic [31:0] rdata_o,
  // Public key store
  input wire logic key_store_i,
  input wire logic [3:0] key_slot_i,
  input wire logic [255:0] key_x_i,
  input wire logic [255:0] key_y_i,
  // Parameter layout
  input wire logic fmt_load_i,
  input wire logic [255:0] priv_key_i,
  input wire logic [255:0] sig_r_i,
  input wire logic [255:0] sig_s_i,
  output logic [287:0] priv_param_o,
  output logic [511:0] sig_param_o,
  output logic [511:0] key_param_o
);

  //------------------------------------------------------------------
  // State
  //------------------------------------------------------------------
  typedef enum logic [2:0] {
    H_IDLE = 3'b001, // Ready for a user operation
    H_SEND = 3'b010, // Holding a request
    H_WAIT = 3'b100 // Waiting for the answer
  } dsak_hst_t;

  typedef struct packed {
    dsak_hst_t st; // Control state
    logic op_ready; // User may start
    logic req_valid; // Link request
    logic [2:0] req_cmd; // Link command
    logic [15:0] req_addr; // Link address
    logic [31:0] req_data; // Link data
    logic storing; // Key store sequence running
    logic [4:0] kcnt; // Key word being written
    logic [3:0] kslot; // Target slot
    logic [255:0] kx; // Held X coordinate
    logic [255:0] ky; // Held Y coordinate
    logic done; // Completion strobe
    logic [7:0] status; // Last status
    logic [31:0] rdata; // Last read word
    logic [287:0] priv_param; // Private key parameter
    logic [511:0] sig_param; // Signature parameter
    logic [511:0] key_param; // Command form public key
  } dsak_hstate_t;

  dsak_hstate_t s; // Registered state
  dsak_hstate_t n; // Next state
  logic [4:0] knext; // Following key word

  //------------------------------------------------------------------
  // Next state
  //------------------------------------------------------------------
  always_comb begin
    n = s;
    n.done = 1'b0;
    knext = 5'(s.kcnt + 5'h01);
    // Layouts are built on request, independent of the link
    if (fmt_load_i) begin
      n.priv_param = {32'h00000000, priv_key_i};
      n.sig_param = {sig_r_i, sig_s_i};
      n.key_param = {key_x_i, key_y_i};
    end
    unique case (s.st)
      H_IDLE: begin
        // Key store wins over a plain operation in the same cycle
        if (key_store_i && s.op_ready) begin
          n.op_ready = 1'b0;
          n.storing = 1'b1;
          n.kcnt = 5'h00;
          n.kslot = key_slot_i;
          n.kx = key_x_i;
          n.ky = key_y_i;
          n.req_valid = 1'b1;
          n.req_cmd = dsak_pkg::CMD_WRITE;
          n.req_addr = dsak_pkg::dsak_key_addr(key_slot_i, 5'h00);
          n.req_data = dsak_pkg::dsak_stored_word(key_x_i, key_y_i,
                                                  5'h00);
          n.st = H_SEND;
        end else if (op_valid_i && s.op_ready) begin
          n.op_ready = 1'b0;
          n.storing = 1'b0;
          n.req_valid = 1'b1;
          n.req_cmd = op_cmd_i;
          n.req_addr = op_addr_i;
          n.req_data = op_data_i;
          n.st = H_SEND;
        end
      end
      H_SEND: begin
        if (link.req_ready) begin
          n.req_valid = 1'b0;
          n.st = H_WAIT;
        end
      end
      H_WAIT: begin
        if (link.rsp_valid) begin
          // A refused word ends the key store at once
          if (s.storing && link.rsp_status == dsak_pkg::STATUS_OK &&
              s.kcnt != dsak_pkg::KEY_LAST_WORD) begin
            n.kcnt = knext;
            n.req_valid = 1'b1;
            n.req_addr = dsak_pkg::dsak_key_addr(s.kslot, knext);
            n.req_data = dsak_pkg::dsak_stored_word(s.kx, s.ky,
                                                    knext);
            n.st = H_SEND;
          end else begin
            n.done = 1'b1;
            n.status = link.rsp_status;
            n.rdata = link.rsp_data;
            n.storing = 1'b0;
            n.op_ready = 1'b1;
            n.st = H_IDLE;
          end
        end
      end
      default: begin
        // Illegal one-hot code recovers to idle
        n.st = H_IDLE;
        n.req_valid = 1'b0;
        n.op_ready = 1'b1;
      end
    endcase
  end

  //------------------------------------------------------------------
  // State register
  //------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '0;
      s.st <= H_IDLE;
      s.op_ready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  //------------------------------------------------------------------
  // Outputs
  //------------------------------------------------------------------
  assign link.req_valid = s.req_valid;
  assign link.req_cmd = s.req_cmd;
  assign link.req_addr = s.req_addr;
  assign link.req_data = s.req_data;
  assign op_ready_o = s.op_ready;
  assign done_o = s.done;
  assign status_o = s.status;
  assign rdata_o = s.rdata;
  assign priv_param_o = s.priv_param;
  assign sig_param_o = s.sig_param;
  assign key_param_o = s.key_param;

endmodule

// File: verification/dsak_link_checker.sv
// Timing and address policy assertions on the data slot word link
module dsak_link_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Link signals
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [2:0] req_cmd,
  input wire logic [15:0] req_addr,
  input wire logic [31:0] req_data,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_status,
  input wire logic [31:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Helpers
  // ----------
  logic tk; // Request taken at this edge
  logic [3:0] sl; // Addressed slot
  logic rd; // Taken read
  assign tk = req_valid && req_ready;
  assign sl = req_addr[6:3];
  assign rd = tk && req_cmd == dsak_pkg::CMD_READ;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Refusal answer
  sequence err_s;
    rsp_valid && rsp_status == dsak_pkg::STATUS_EXEC_ERR;
  endsequence
  // One-cycle answer, then ready again
  sequence ans_s;
    rsp_valid && !req_ready ##1 !rsp_valid && req_ready;
  endsequence
  // Hash streams stay silent at first, so an early answer is caught
  sequence quiet_s;
    !rsp_valid [*8];
  endsequence
  // ----------
  // Assertions
  // ----------
  chk_word_answer:
    assert property (tk && req_cmd < dsak_pkg::CMD_HASH_GENKEY |=> ans_s)
    else $error("word answer timing wrong");
  chk_stored_len:
    assert property (tk && req_cmd == dsak_pkg::CMD_HASH_STORED &&
      sl >= 4'h8 |=> quiet_s ##65 rsp_valid) else $error("stored hash length");
  chk_genkey_len:
    assert property (tk && req_cmd == dsak_pkg::CMD_HASH_GENKEY &&
      sl >= 4'h8 |=> quiet_s ##82 rsp_valid) else $error("key hash length");
  chk_slot8_end:
    assert property (rd && sl == 4'h8 && req_addr[11:8] > 4'hc |=> err_s)
    else $error("slot 8 block past end taken");
  chk_slot8_ok:
    assert property (rd && sl == 4'h8 && req_addr[11:8] <= 4'hc |=>
      rsp_status == 8'h00) else $error("slot 8 block refused");
  chk_large_gap:
    assert property (rd && sl > 4'h8 && (req_addr[9:8] == 2'h3 ||
      (req_addr[9:8] == 2'h2 && req_addr[2:0] > 3'h1)) |=> err_s)
    else $error("slot 9-15 gap taken");
  chk_write_mask:
    assert property (tk && req_cmd == dsak_pkg::CMD_WRITE &&
      !(sl inside {4'h8, 4'h9, 4'hd, 4'hf}) |=> err_s)
    else $error("clear write allowed");
  chk_enc_mask:
    assert property (tk && req_cmd == dsak_pkg::CMD_WRITE_ENC &&
      !(sl inside {4'h5, 4'h6}) |=> err_s) else $error("enc write allowed");
  chk_err_data:
    assert property (rsp_valid && rsp_status != 8'h00 |-> rsp_data == '0)
    else $error("refused answer carries data");
  chk_req_hold:
    assert property (req_valid && !req_ready |=> req_valid &&
      $stable(req_addr) && $stable(req_data)) else $error("request dropped");
endmodule

// File: verification/dsak_tb.sv
// Self-checking bench joining host and device ends over the word link
module dsak_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Signals
  // ----------
  logic clk_i, sys_rst_i, op_valid_i, key_store_i, fmt_load_i;
  logic op_ready_o, done_o, sha_valid_o, sha_last_o;
  logic [2:0] op_cmd_i;
  logic [3:0] key_slot_i;
  logic [7:0] status_o, sha_byte_o;
  logic [15:0] op_addr_i, validation_slots_i;
  logic [31:0] op_data_i, rdata_o;
  logic [255:0] key_x_i, key_y_i, priv_key_i, sig_r_i, sig_s_i;
  logic [287:0] priv_param_o;
  logic [511:0] sig_param_o, key_param_o;
  logic [7:0] shaq[$]; // Hash bytes seen
  int bad_count, checks_done;
  int last_at; // Bytes seen when the final marker showed
  dsak_link_if link ();
  dsak_device i_dsak_device (.clk_i, .sys_rst_i, .link,
    .validation_slots_i, .sha_valid_o, .sha_byte_o, .sha_last_o);
  dsak_host i_dsak_host (.clk_i, .sys_rst_i, .link, .op_valid_i, .op_cmd_i,
    .op_addr_i, .op_data_i, .op_ready_o, .done_o, .status_o, .rdata_o,
    .key_store_i, .key_slot_i, .key_x_i, .key_y_i, .fmt_load_i, .priv_key_i,
    .sig_r_i, .sig_s_i, .priv_param_o, .sig_param_o, .key_param_o);
  dsak_link_checker i_dsak_link_checker (.clk_i, .sys_rst_i,
    .req_valid(link.req_valid), .req_ready(link.req_ready),
    .req_cmd(link.req_cmd), .req_addr(link.req_addr),
    .req_data(link.req_data), .rsp_valid(link.rsp_valid),
    .rsp_status(link.rsp_status), .rsp_data(link.rsp_data));
  // ----------
  // Tasks
  // ----------
  // Compare and count
  task automatic chk(input logic [511:0] s, input logic [511:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Drop requests after the taking edge, then wait for done, bounded
  task automatic wait_done();
    int n;
    n = 0;
    @(negedge clk_i);
    op_valid_i = 1'b0;
    key_store_i = 1'b0;
    while (done_o !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 300) bad_count++;
  endtask
  // One word command through the host
  task automatic op(input logic [2:0] c, input logic [15:0] a,
                    input logic [31:0] d);
    op_cmd_i = c;
    op_addr_i = a;
    op_data_i = d;
    op_valid_i = 1'b1;
    wait_done();
  endtask
  // Command plus status and read word compare
  task automatic tx(input logic [2:0] c, input logic [15:0] a,
                    input logic [31:0] d, input logic [7:0] st,
                    input logic [31:0] rw);
    op(c, a, d);
    chk(status_o, st);
    chk(rdata_o, rw);
  endtask
  // ----------
  // Clock, hash capture, watchdog
  // ----------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Sampled mid-cycle, away from the edge that launches each byte
  always @(negedge clk_i) begin
    if (sha_valid_o === 1'b1) shaq.push_back(sha_byte_o);
    if (sha_last_o === 1'b1) last_at = shaq.size();
  end
  // Whole run needs about 425 cycles
  initial begin
    #200000;
    bad_count++;
    results();
  end
  // ----------
  // Main sequence
  // ----------
  initial begin
    {sys_rst_i, op_valid_i, key_store_i, fmt_load_i} = 4'h8;
    {op_cmd_i, op_addr_i, op_data_i} = '0;
    key_slot_i = 4'hd;
    validation_slots_i = 16'h2000; // Only slot 13 carries a nibble
    for (int i = 0; i < 8; i++) begin
      key_x_i[32*i+:32] = 32'hb2be0000 + i;
      key_y_i[32*i+:32] = 32'ha8290000 + i;
    end
    priv_key_i = key_y_i;
    sig_r_i = key_x_i;
    sig_s_i = ~key_y_i;
    repeat (12) @(negedge clk_i);
    sys_rst_i = 1'b0;
    // Slot 8: last word, ignored high bits, block past the end
    tx(dsak_pkg::CMD_WRITE, 16'h0c47, 32'h1234abcd, 8'h00, 0);
    tx(dsak_pkg::CMD_READ, 16'hfc47, 0, 8'h00, 32'h1234abcd);
    tx(dsak_pkg::CMD_READ, 16'h0d47, 0, 8'h0f, 0);
    // Slots 9-15: short last block; then an unknown command
    tx(dsak_pkg::CMD_WRITE, 16'h0279, 32'hcafe0f0f, 8'h00, 0);
    tx(dsak_pkg::CMD_READ, 16'hfe79, 0, 8'h00, 32'hcafe0f0f);
    tx(dsak_pkg::CMD_READ, 16'h027a, 0, 8'h0f, 0);
    tx(dsak_pkg::CMD_READ, 16'h0378, 0, 8'h0f, 0);
    tx(3'h7, 16'h0040, 0, 8'h0f, 0);
    // Access policy over every slot
    for (int s = 0; s < 16; s++) begin
      op(dsak_pkg::CMD_WRITE, {9'h0, 4'(s), 3'h0}, 0);
      chk(status_o, s inside {8, 9, 13, 15} ? 8'h00 : 8'h0f);
      op(dsak_pkg::CMD_READ, {9'h0, 4'(s), 3'h0}, 0);
      chk(status_o, (s == 8 || s >= 10) ? 8'h00 : 8'h0f);
      op(dsak_pkg::CMD_WRITE_ENC, {9'h0, 4'(s), 3'h0}, 0);
      chk(status_o, s inside {5, 6} ? 8'h00 : 8'h0f);
    end
    // Stored key layout in slot 13
    key_store_i = 1'b1;
    wait_done();
    chk(status_o, 8'h00);
    chk(op_ready_o, 1'b1);
    tx(dsak_pkg::CMD_READ, 16'h0068, 0, 8'h00, 32'ha0000000);
    tx(dsak_pkg::CMD_READ, 16'h0069, 0, 8'h00, key_x_i[255:224]);
    tx(dsak_pkg::CMD_READ, 16'h0169, 0, 8'h00, 0);
    tx(dsak_pkg::CMD_READ, 16'h016a, 0, 8'h00, key_y_i[255:224]);
    tx(dsak_pkg::CMD_READ, 16'h0269, 0, 8'h00, key_y_i[31:0]);
    // Validation nibble life cycle
    tx(dsak_pkg::CMD_VALIDATE, 16'h0068, 0, 8'h00, 0);
    tx(dsak_pkg::CMD_READ, 16'h0068, 0, 8'h00, 32'h50000000);
    tx(dsak_pkg::CMD_VALIDATE, 16'h0078, 0, 8'h0f, 0);
    shaq.delete();
    tx(dsak_pkg::CMD_HASH_STORED, 16'h0068, 0, 8'h00, 0);
    chk(shaq.size(), 72);
    chk(last_at, 72);
    chk({shaq[0], shaq[4], shaq[71]}, {8'h50, 8'hb2, 8'h00});
    shaq.delete();
    tx(dsak_pkg::CMD_HASH_GENKEY, 16'h0068, 0, 8'h00, 0);
    chk(shaq.size(), 89);
    chk(last_at, 89);
    chk({shaq[24], shaq[25], shaq[57], shaq[88]}, 32'h00b2a800);
    tx(dsak_pkg::CMD_INVALIDATE, 16'h0068, 0, 8'h00, 0);
    tx(dsak_pkg::CMD_READ, 16'h0068, 0, 8'h00, 32'ha0000000);
    tx(dsak_pkg::CMD_VALIDATE, 16'h0068, 0, 8'h00, 0);
    tx(dsak_pkg::CMD_WRITE, 16'h006d, 32'h0badf00d, 8'h00, 0);
    tx(dsak_pkg::CMD_READ, 16'h0068, 0, 8'h00, 32'ha0000000);
    // Parameter layouts
    fmt_load_i = 1'b1;
    @(negedge clk_i);
    fmt_load_i = 1'b0;
    chk(priv_param_o, {32'h0, priv_key_i});
    chk(sig_param_o, {sig_r_i, sig_s_i});
    chk(key_param_o, {key_x_i, key_y_i});
    results();
  end
endmodule
